// *** src/iprc_pkg.sv ***
// Package: register map, field layout and timing constants of the interrupt controller
package iprc_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_REQ1 = 8'h00;
    localparam logic [7:0] OFF_REQ2 = 8'h04;
    localparam logic [7:0] OFF_WAKE_FLAGS = 8'h08;
    localparam logic [7:0] OFF_EN1 = 8'h0C;
    localparam logic [7:0] OFF_EN2 = 8'h10;
    localparam logic [7:0] OFF_EDGE = 8'h14;
    localparam logic [7:0] OFF_PIN_FUNC = 8'h18;
    localparam logic [7:0] OFF_WAKE_FUNC = 8'h1C;
    localparam logic [7:0] OFF_CCR = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int EXT_IRQ_N = 5;
    localparam int WAKE_N = 8;
    localparam int INT_N = 20;
    localparam int INT_IN_REQ1 = 10;
    localparam int WAKE_EN_POS = 5;
    localparam int INT_REQ1_LSB = 6;
    localparam int CCR_I_POS = 7;
    localparam int SRC_N = EXT_IRQ_N + WAKE_N + INT_N;
    localparam logic [15:0] RESET_16 = 16'h0000;
    localparam logic [7:0] RESET_8 = 8'h00;
    localparam logic CCR_I_RESET = 1'b1;
    // ****************************************************************
    // Vector numbers
    // ****************************************************************
    localparam logic [4:0] VEC_IRQ_BASE = 5'h04;
    localparam logic [4:0] VEC_WAKE = 5'h09;
    localparam logic [4:0] VEC_INT_BASE = 5'h0A;
    localparam int VEC_INT_SPAN = 11;
    // ****************************************************************
    // Exception sequence lengths, one state per clock
    // ****************************************************************
    localparam logic [3:0] STACK_STATES = 4'h4;
    localparam logic [3:0] VFETCH_STATES = 4'h2;
    localparam logic [3:0] IFETCH_STATES = 4'h4;
    localparam logic [3:0] INTERNAL_STATES = 4'h4;
    localparam logic [15:0] STACK_PC_OFS = 16'h0002;
    localparam logic [15:0] STACK_CCR_OFS = 16'h0004;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_STACK = 5'h02,
        ST_VFETCH = 5'h04,
        ST_IFETCH = 5'h08,
        ST_INTERNAL = 5'h10
    } iprc_state_type;
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [15:0] data;
    } iprc_stack_type;
endpackage : iprc_pkg

// *** src/iprc_ctrl.sv ***
// Interrupt request flags, priority selection and exception sequencing with APB registers
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module iprc_ctrl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] wakeup_pin_n,
    input wire logic [4:0] edge_pin,
    input wire logic [19:0] periph_req,
    input wire logic cpu_insn_end,
    input wire logic [15:0] cpu_pc,
    input wire logic [15:0] cpu_sp,
    input wire logic [6:0] cpu_ccr_low,
    input wire logic cpu_rte,
    input wire logic [15:0] cpu_rte_ccr_word,
    input wire logic [15:0] vec_rdata,
    output iprc_pkg::iprc_stack_type stack_bus,
    output logic [15:0] new_sp,
    output logic vec_rd,
    output logic [15:0] vec_addr,
    output logic [4:0] vector_num,
    output logic handler_go,
    output logic [15:0] handler_pc,
    output logic global_mask
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    // Source index order is the fixed priority order, index 0 highest
    function automatic logic [4:0] vec_of(input int idx);
        if (idx < iprc_pkg::EXT_IRQ_N) begin
            vec_of = iprc_pkg::VEC_IRQ_BASE + 5'(idx);
        end else if (idx < iprc_pkg::EXT_IRQ_N + iprc_pkg::WAKE_N) begin
            vec_of = iprc_pkg::VEC_WAKE;
        end else begin
            vec_of = iprc_pkg::VEC_INT_BASE + 5'(((idx - iprc_pkg::EXT_IRQ_N
                - iprc_pkg::WAKE_N) * iprc_pkg::VEC_INT_SPAN) / iprc_pkg::INT_N);
        end
    endfunction : vec_of
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit
    // ****************************************************************
    // Pin synchronisers and edge detect
    // ****************************************************************
    logic [7:0] wk_s1_reg, wk_s2_reg, wk_s3_reg;
    logic [4:0] ed_s1_reg, ed_s2_reg, ed_s3_reg;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wk_s1_reg <= 8'hFF;
            wk_s2_reg <= 8'hFF;
            wk_s3_reg <= 8'hFF;
            ed_s1_reg <= 5'h00;
            ed_s2_reg <= 5'h00;
            ed_s3_reg <= 5'h00;
        end else begin
            wk_s1_reg <= wakeup_pin_n;
            wk_s2_reg <= wk_s1_reg;
            wk_s3_reg <= wk_s2_reg;
            ed_s1_reg <= edge_pin;
            ed_s2_reg <= ed_s1_reg;
            ed_s3_reg <= ed_s2_reg;
        end
    end
    logic [7:0] wake_fall;
    logic [4:0] edge_rise, edge_fall, edge_hit;
    logic [15:0] edge_sel_reg, pin_func_reg, wake_func_reg;
    assign wake_fall = wk_s3_reg & ~wk_s2_reg & wake_func_reg[7:0];
    assign edge_rise = ~ed_s3_reg & ed_s2_reg;
    assign edge_fall = ed_s3_reg & ~ed_s2_reg;
    assign edge_hit = pin_func_reg[4:0]
        & ((edge_sel_reg[4:0] & edge_rise) | (~edge_sel_reg[4:0] & edge_fall));
    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic acc, wr_done, mapped;
    logic [15:0] req1_reg, req2_reg, en1_reg, en2_reg;
    logic [7:0] wake_flag_reg;
    logic ccr_i_reg;
    iprc_pkg::iprc_state_type state_reg;
    logic [4:0] vec_reg;
    assign acc = psel && penable;
    assign wr_done = acc && pready_reg && pwrite;
    assign mapped = hit(paddr, iprc_pkg::OFF_REQ1) || hit(paddr, iprc_pkg::OFF_REQ2)
        || hit(paddr, iprc_pkg::OFF_WAKE_FLAGS) || hit(paddr, iprc_pkg::OFF_EN1)
        || hit(paddr, iprc_pkg::OFF_EN2) || hit(paddr, iprc_pkg::OFF_EDGE)
        || hit(paddr, iprc_pkg::OFF_PIN_FUNC) || hit(paddr, iprc_pkg::OFF_WAKE_FUNC)
        || hit(paddr, iprc_pkg::OFF_CCR) || hit(paddr, iprc_pkg::OFF_STATUS);
    // Two-cycle access phase keeps pready straight from a flop
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            prdata_reg <= 32'h0000_0000;
            if (acc && !pready_reg && !pwrite) begin
                case (paddr)
                    iprc_pkg::OFF_REQ1: prdata_reg <= {16'h0000, req1_reg};
                    iprc_pkg::OFF_REQ2: prdata_reg <= {16'h0000, req2_reg};
                    iprc_pkg::OFF_WAKE_FLAGS: prdata_reg <= {24'h000000, wake_flag_reg};
                    iprc_pkg::OFF_EN1: prdata_reg <= {16'h0000, en1_reg};
                    iprc_pkg::OFF_EN2: prdata_reg <= {16'h0000, en2_reg};
                    iprc_pkg::OFF_EDGE: prdata_reg <= {16'h0000, edge_sel_reg};
                    iprc_pkg::OFF_PIN_FUNC: prdata_reg <= {16'h0000, pin_func_reg};
                    iprc_pkg::OFF_WAKE_FUNC: prdata_reg <= {16'h0000, wake_func_reg};
                    iprc_pkg::OFF_CCR: prdata_reg <= {24'h000000, ccr_i_reg, 7'h00};
                    iprc_pkg::OFF_STATUS: prdata_reg <= {19'h00000, vec_reg, 3'h0, state_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    // ****************************************************************
    // Control registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            en1_reg <= iprc_pkg::RESET_16;
            en2_reg <= iprc_pkg::RESET_16;
            edge_sel_reg <= iprc_pkg::RESET_16;
            pin_func_reg <= iprc_pkg::RESET_16;
            wake_func_reg <= iprc_pkg::RESET_16;
        end else if (wr_done) begin
            if (hit(paddr, iprc_pkg::OFF_EN1)) en1_reg <= pwdata[15:0];
            if (hit(paddr, iprc_pkg::OFF_EN2)) en2_reg <= pwdata[15:0];
            if (hit(paddr, iprc_pkg::OFF_EDGE)) edge_sel_reg <= {11'h000, pwdata[4:0]};
            if (hit(paddr, iprc_pkg::OFF_PIN_FUNC)) pin_func_reg <= {11'h000, pwdata[4:0]};
            if (hit(paddr, iprc_pkg::OFF_WAKE_FUNC)) wake_func_reg <= {8'h00, pwdata[7:0]};
        end
    end
    // ****************************************************************
    // Request flags: set wins over a clearing write
    // ****************************************************************
    logic [15:0] set1, set2, clr1, clr2;
    logic [7:0] clrw;
    assign set1 = {periph_req[iprc_pkg::INT_IN_REQ1-1:0], 1'b0, edge_hit};
    assign set2 = {6'h00, periph_req[iprc_pkg::INT_N-1:iprc_pkg::INT_IN_REQ1]};
    assign clr1 = (wr_done && hit(paddr, iprc_pkg::OFF_REQ1)) ? ~pwdata[15:0] : 16'h0000;
    assign clr2 = (wr_done && hit(paddr, iprc_pkg::OFF_REQ2)) ? ~pwdata[15:0] : 16'h0000;
    assign clrw = (wr_done && hit(paddr, iprc_pkg::OFF_WAKE_FLAGS)) ? ~pwdata[7:0] : 8'h00;
    // Acceptance never touches the flags
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            req1_reg <= iprc_pkg::RESET_16;
            req2_reg <= iprc_pkg::RESET_16;
            wake_flag_reg <= iprc_pkg::RESET_8;
        end else begin
            req1_reg <= (req1_reg & ~clr1) | set1;
            req2_reg <= (req2_reg & ~clr2) | set2;
            wake_flag_reg <= (wake_flag_reg & ~clrw) | wake_fall;
        end
    end
    // ****************************************************************
    // Priority selection
    // ****************************************************************
    logic [iprc_pkg::SRC_N-1:0] pend;
    logic any_pend;
    logic [4:0] win_vec;
    int win_idx;
    assign pend = {req2_reg[iprc_pkg::INT_N-iprc_pkg::INT_IN_REQ1-1:0] & en2_reg[9:0],
        req1_reg[15:iprc_pkg::INT_REQ1_LSB] & en1_reg[15:iprc_pkg::INT_REQ1_LSB],
        wake_flag_reg & {8{en1_reg[iprc_pkg::WAKE_EN_POS]}},
        req1_reg[4:0] & en1_reg[4:0]};
    assign any_pend = |pend;
    always_comb begin
        win_idx = 0;
        win_vec = 5'h00;
        for (int i = iprc_pkg::SRC_N - 1; i >= 0; i--) begin
            if (pend[i]) begin
                win_idx = i;
                win_vec = vec_of(i);
            end
        end
    end
    // ****************************************************************
    // Exception sequence
    // ****************************************************************
    logic accept;
    logic [3:0] cnt_reg;
    logic [15:0] pc_reg, sp_reg, hpc_reg, vaddr_reg, nsp_reg;
    logic go_reg, vrd_reg;
    iprc_pkg::iprc_stack_type stk_reg;
    // A bus access in flight may be clearing a flag, so it finishes first
    assign accept = (state_reg == iprc_pkg::ST_IDLE) && any_pend && !ccr_i_reg
        && cpu_insn_end && !psel;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= iprc_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            vec_reg <= 5'h00;
            pc_reg <= 16'h0000;
            sp_reg <= 16'h0000;
        end else begin
            case (state_reg)
                iprc_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_reg <= iprc_pkg::ST_STACK;
                        vec_reg <= win_vec;
                        pc_reg <= cpu_pc;
                        sp_reg <= {cpu_sp[15:1], 1'b0};
                        cnt_reg <= 4'h0;
                    end
                end
                iprc_pkg::ST_STACK: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == iprc_pkg::STACK_STATES - 4'h1) begin
                        state_reg <= iprc_pkg::ST_VFETCH;
                        cnt_reg <= 4'h0;
                    end
                end
                iprc_pkg::ST_VFETCH: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == iprc_pkg::VFETCH_STATES - 4'h1) begin
                        state_reg <= iprc_pkg::ST_IFETCH;
                        cnt_reg <= 4'h0;
                    end
                end
                iprc_pkg::ST_IFETCH: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == iprc_pkg::IFETCH_STATES - 4'h1) begin
                        state_reg <= iprc_pkg::ST_INTERNAL;
                        cnt_reg <= 4'h0;
                    end
                end
                iprc_pkg::ST_INTERNAL: begin
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == iprc_pkg::INTERNAL_STATES - 4'h1) begin
                        state_reg <= iprc_pkg::ST_IDLE;
                        cnt_reg <= 4'h0;
                    end
                end
                default: begin
                    state_reg <= iprc_pkg::ST_IDLE;
                    cnt_reg <= 4'h0;
                end
            endcase
        end
    end
    // Stack pushes, vector fetch and handler start
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            stk_reg <= '0;
            nsp_reg <= 16'h0000;
            vrd_reg <= 1'b0;
            vaddr_reg <= 16'h0000;
            hpc_reg <= 16'h0000;
            go_reg <= 1'b0;
        end else begin
            stk_reg.we <= 1'b0;
            vrd_reg <= 1'b0;
            go_reg <= 1'b0;
            if (state_reg == iprc_pkg::ST_STACK && cnt_reg == 4'h0) begin
                stk_reg.we <= 1'b1;
                stk_reg.addr <= sp_reg - iprc_pkg::STACK_PC_OFS;
                stk_reg.data <= pc_reg;
            end
            if (state_reg == iprc_pkg::ST_STACK && cnt_reg == 4'h2) begin
                stk_reg.we <= 1'b1;
                stk_reg.addr <= sp_reg - iprc_pkg::STACK_CCR_OFS;
                // Mask had to be clear to accept, so the pushed I bit is zero
                stk_reg.data <= {1'b0, cpu_ccr_low, 1'b0, cpu_ccr_low};
                nsp_reg <= sp_reg - iprc_pkg::STACK_CCR_OFS;
            end
            if (state_reg == iprc_pkg::ST_VFETCH && cnt_reg == 4'h0) begin
                vrd_reg <= 1'b1;
                vaddr_reg <= {10'h000, vec_reg, 1'b0};
            end
            // Table word stands one cycle after the read strobe
            if (state_reg == iprc_pkg::ST_IFETCH && cnt_reg == 4'h0) begin
                hpc_reg <= {vec_rdata[15:1], 1'b0};
            end
            if (state_reg == iprc_pkg::ST_INTERNAL
                && cnt_reg == iprc_pkg::INTERNAL_STATES - 4'h1) begin
                go_reg <= 1'b1;
            end
        end
    end
    // Global mask: set on acceptance, restored from the even byte on return
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ccr_i_reg <= iprc_pkg::CCR_I_RESET;
        end else if (accept) begin
            ccr_i_reg <= 1'b1;
        end else if (cpu_rte) begin
            ccr_i_reg <= cpu_rte_ccr_word[8 + iprc_pkg::CCR_I_POS];
        end else if (wr_done && hit(paddr, iprc_pkg::OFF_CCR)) begin
            ccr_i_reg <= pwdata[iprc_pkg::CCR_I_POS];
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign stack_bus = stk_reg;
    assign new_sp = nsp_reg;
    assign vec_rd = vrd_reg;
    assign vec_addr = vaddr_reg;
    assign vector_num = vec_reg;
    assign handler_go = go_reg;
    assign handler_pc = hpc_reg;
    assign global_mask = ccr_i_reg;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_accept;
        accept;
    endsequence
    sequence s_go_after_walk;
        ##15 handler_go;
    endsequence
    property p_latency;
        @(posedge sys_clk) disable iff (!nrst) s_accept |-> s_go_after_walk;
    endproperty
    a_latency: assert property (p_latency) else $error("handler start not 15 cycles after accept");
    property p_mask_set;
        @(posedge sys_clk) disable iff (!nrst) accept |=> global_mask;
    endproperty
    a_mask_set: assert property (p_mask_set) else $error("mask not set on acceptance");
    property p_masked_hold;
        @(posedge sys_clk) disable iff (!nrst)
            global_mask && state_reg == iprc_pkg::ST_IDLE |=> state_reg == iprc_pkg::ST_IDLE;
    endproperty
    a_masked_hold: assert property (p_masked_hold) else $error("accepted while masked");
    property p_even_stack;
        @(posedge sys_clk) disable iff (!nrst) stack_bus.we |-> stack_bus.addr[0] == 1'b0;
    endproperty
    a_even_stack: assert property (p_even_stack) else $error("odd stack address");
    property p_wake_vec;
        @(posedge sys_clk) disable iff (!nrst)
            accept && win_idx >= 5 && win_idx <= 12 |=> vector_num == 5'h09;
    endproperty
    a_wake_vec: assert property (p_wake_vec) else $error("wakeup vector not nine");
    property p_wake_gate;
        @(posedge sys_clk) disable iff (!nrst) !en1_reg[5] |-> pend[12:5] == 8'h00;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wakeup pending while disabled");
    property p_flag_kept;
        @(posedge sys_clk) disable iff (!nrst)
            wake_flag_reg[5] && !(wr_done && hit(paddr, iprc_pkg::OFF_WAKE_FLAGS))
            |=> wake_flag_reg[5];
    endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("wakeup flag lost");
    property p_rise_sets;
        @(posedge sys_clk) disable iff (!nrst)
            $rose(ed_s2_reg[0]) && edge_sel_reg[0] && pin_func_reg[0] |=> req1_reg[0];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge not flagged");
    property p_clear_first;
        @(posedge sys_clk) disable iff (!nrst)
            psel && state_reg == iprc_pkg::ST_IDLE |=> state_reg == iprc_pkg::ST_IDLE;
    endproperty
    a_clear_first: assert property (p_clear_first) else $error("accepted during bus access");
endmodule : iprc_ctrl

// *** verification/iprc_cpu_model.sv ***
// CPU-side model: instruction boundaries, vector table reads and exception return
`timescale 1ns/1ps
module iprc_cpu_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic rte_req,
    input wire iprc_pkg::iprc_stack_type stack_bus,
    input wire logic vec_rd,
    input wire logic [15:0] vec_addr,
    output logic cpu_insn_end,
    output logic [15:0] cpu_pc,
    output logic [15:0] cpu_sp,
    output logic [6:0] cpu_ccr_low,
    output logic cpu_rte,
    output logic [15:0] cpu_rte_ccr_word,
    output logic [15:0] vec_rdata
);
    // ****
    // Core behaviour
    // ****
    logic [3:0] cnt_reg;
    logic [15:0] ccr_word_reg;
    assign cpu_pc = 16'h0246;
    // Odd on purpose: pushes must drop bit 0
    assign cpu_sp = 16'h0FF1;
    assign cpu_ccr_low = 7'h2A;
    assign cpu_insn_end = (cnt_reg == 4'h0);
    always_ff @(posedge sys_clk) begin
        if (!nrst || cnt_reg == (slow ? 4'hC : 4'h2)) begin
            cnt_reg <= 4'h0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // Table word only in the sampled cycle, churning otherwise
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            vec_rdata <= 16'h5555;
        end else if (vec_rd) begin
            vec_rdata <= {vec_addr[7:0], 8'h31};
        end else begin
            vec_rdata <= ~vec_rdata;
        end
    end
    // Odd byte inverted so that restoring it would show
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ccr_word_reg <= 16'h0000;
        end else if (stack_bus.we) begin
            ccr_word_reg <= stack_bus.data;
        end
        cpu_rte <= nrst & rte_req;
        cpu_rte_ccr_word <= {ccr_word_reg[15:8], ~ccr_word_reg[7:0]};
    end
endmodule : iprc_cpu_model

// *** verification/tb.sv ***
// Self-checking bench for the interrupt controller with a CPU model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    // ****
    // Signals and instances
    // ****
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, e;
    logic cpu_insn_end, cpu_rte, vec_rd, handler_go, global_mask, slow, rte_req;
    logic [7:0] paddr, wakeup_pin_n;
    logic [31:0] pwdata, prdata, q;
    logic [4:0] edge_pin, vector_num;
    logic [19:0] periph_req;
    logic [15:0] cpu_pc, cpu_sp, cpu_rte_ccr_word, vec_rdata, new_sp, vec_addr, handler_pc;
    logic [6:0] cpu_ccr_low;
    iprc_pkg::iprc_stack_type stack_bus;
    logic [32:0] stk[$];
    int num_errors = 0;
    int n_compared = 0;
    int k;
    logic [4:0] vecs [3] = '{5'h07, 5'h09, 5'h10};
    logic [7:0] clr_off [3] = '{iprc_pkg::OFF_REQ1, iprc_pkg::OFF_WAKE_FLAGS, iprc_pkg::OFF_REQ2};
    logic [31:0] clr_val [3] = '{32'hFFFFFFF7, 32'hFFFFFFDF, 32'hFFFFFFFB};
    iprc_ctrl u_iprc_ctrl (.*);
    iprc_cpu_model u_iprc_cpu_model (.*);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (stack_bus.we === 1'b1) stk.push_back(stack_bus);
    task results;
        if (num_errors == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        if (n >= 16) begin num_errors++; results(); end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, ex, q)
    endtask : rd
    task automatic wait_mask(input logic lvl);
        int n;
        n = 0;
        while (global_mask !== lvl && n < 40) begin @(posedge sys_clk); n++; end
        if (n >= 40) begin num_errors++; results(); end
    endtask : wait_mask
    // ****
    // Scenarios
    // ****
    initial begin
        {nrst, psel, penable, pwrite, slow, rte_req} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        edge_pin = 5'h08;
        wakeup_pin_n = 8'hFF;
        periph_req = 20'h0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(iprc_pkg::OFF_CCR, 32'h80, "ccr_reset");
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 1'b1, e)
        apb(1'b1, iprc_pkg::OFF_PIN_FUNC, 32'h1F);
        apb(1'b1, iprc_pkg::OFF_WAKE_FUNC, 32'hFF);
        apb(1'b1, iprc_pkg::OFF_EDGE, 32'h05);
        apb(1'b1, iprc_pkg::OFF_EN1, 32'h28);
        apb(1'b1, iprc_pkg::OFF_EN2, 32'h04);
        edge_pin <= 5'h05;
        wakeup_pin_n <= 8'hDF;
        periph_req <= 20'h01000;
        @(posedge sys_clk);
        periph_req <= 20'h0;
        repeat (6) @(posedge sys_clk);
        rd(iprc_pkg::OFF_REQ1, 32'h0D, "req1");
        rd(iprc_pkg::OFF_WAKE_FLAGS, 32'h20, "wake");
        rd(iprc_pkg::OFF_REQ2, 32'h04, "req2");
        apb(1'b1, iprc_pkg::OFF_REQ1, 32'hFFFFFFFF);
        rd(iprc_pkg::OFF_REQ1, 32'h0D, "req1_ones");
        repeat (30) @(posedge sys_clk);
        `CHK("masked_pushes", 0, stk.size())
        apb(1'b1, iprc_pkg::OFF_CCR, 32'h0);
        for (int i = 0; i < 3; i++) begin
            // Low first: the write or return may not have landed yet
            wait_mask(1'b0);
            wait_mask(1'b1);
            k = 0;
            do begin @(posedge sys_clk); k++; end while (handler_go !== 1'b1 && k < 40);
            `CHK("latency", 14, k)
            `CHK("vector", vecs[i], vector_num)
            `CHK("vec_addr", {10'h000, vecs[i], 1'b0}, vec_addr)
            `CHK("handler", {2'b00, vecs[i], 1'b0, 8'h30}, handler_pc)
            `CHK("push_pc", {1'b1, 16'h0FEE, 16'h0246}, stk[0])
            `CHK("push_ccr", {1'b1, 16'h0FEC, 16'h2A2A}, stk[1])
            `CHK("new_sp", 16'h0FEC, new_sp)
            stk.delete();
            apb(1'b0, clr_off[i], 32'h0);
            `CHK("flag_kept", ~clr_val[i], q & ~clr_val[i])
            apb(1'b1, clr_off[i], clr_val[i]);
            slow <= (i == 0);
            rte_req <= 1'b1;
            @(posedge sys_clk);
            rte_req <= 1'b0;
        end
        repeat (40) @(posedge sys_clk);
        `CHK("disabled_pushes", 0, stk.size())
        rd(iprc_pkg::OFF_CCR, 32'h00, "ccr_restored");
        results();
    end
endmodule : tb
